// >>> hdl/suart_pkg.sv
// Package with the register map, modes, timing counts and carrier types of the serial port.
package suart_pkg;

   // ********************************************************************
   // Register map and reset values
   // ********************************************************************
   localparam logic [7:0] SUART_CTRL_ADDR  = 8'h98; // Control and status register.
   localparam logic [7:0] SUART_DATA_ADDR  = 8'h99; // Data register (write tx, read rx).
   localparam logic [7:0] SUART_CTRL_RESET = 8'h00; // Control register after reset.
   localparam logic [7:0] SUART_DATA_RESET = 8'h00; // Receive data register after reset.

   // ********************************************************************
   // Operating modes held in the two mode-select bits
   // ********************************************************************
   localparam logic [1:0] SUART_MODE_SHIFT = 2'h0; // Synchronous shift register.
   localparam logic [1:0] SUART_MODE_ASY8  = 2'h1; // 8-bit asynchronous, timer rate.
   localparam logic [1:0] SUART_MODE_ASY9F = 2'h2; // 9-bit asynchronous, fixed rate.
   localparam logic [1:0] SUART_MODE_ASY9V = 2'h3; // 9-bit asynchronous, timer rate.

   // ********************************************************************
   // Timing counts
   // ********************************************************************
   localparam logic [3:0] SUART_LAST_TICK   = 4'hF; // Sixteenth rate tick of one bit.
   localparam logic [3:0] SUART_SAMPLE_TICK = 4'h7; // Tick at which mid-bit is sampled.
   localparam logic [2:0] SUART_LAST_SHIFT  = 3'h7; // Eighth bit in shift-register mode.
   localparam logic [3:0] SUART_BITS_8      = 4'hA; // Bits of an 8-bit frame.
   localparam logic [3:0] SUART_BITS_9      = 4'hB; // Bits of a 9-bit frame.
   localparam logic [3:0] SUART_RX_DATA_END = 4'h8; // Received bits before the ninth.
   localparam logic [1:0] SUART_BUF_DEPTH   = 2'h2; // Entries of the transmit buffer.

   // ********************************************************************
   // Carrier for the control register fields
   // ********************************************************************
   typedef struct packed {
      logic [1:0] mode;      // Mode select, high bit first.
      logic       mp_en;     // Multiprocessor filter enable.
      logic       rx_en;     // Receive enable.
      logic       tx_ninth;  // Ninth bit to transmit.
      logic       rx_ninth;  // Ninth bit (or stop bit) received.
      logic       tx_done;   // Transmit done flag.
      logic       rx_done;   // Receive done flag.
   } suart_ctrl_t;

   // Number of bits in one asynchronous frame, start and stop included.
   function automatic logic [3:0] suart_frame_bits(input logic [1:0] mode);
      suart_frame_bits = (mode == SUART_MODE_ASY8) ? SUART_BITS_8 : SUART_BITS_9;
   endfunction

   // True in the two 9-bit asynchronous modes.
   function automatic logic suart_is_nine(input logic [1:0] mode);
      suart_is_nine = mode[1];
   endfunction

endpackage

// >>> hdl/suart_top.sv
// Serial port: control and data registers, transmit buffer, transmitter and receiver.
`timescale 1ns/1ps

// Overview of operation
// - Transmit and receive paths run independently outside shift mode.
// - Second byte assembles while first waits, outside shift mode.
// - Data write loads tx; read returns rx.
// - Mode bits 00, 01, 11 pick modes.
// - Mode 10 is fixed-rate 9-bit mode.
// - 8-bit mode filter needs valid stop bit.
// - 9-bit filter drops frames with ninth zero.
// - Receive only while receive enable set.
// - 9-bit modes send tx ninth bit.
// - Ninth bit or stop bit into rx_ninth.
// - Tx flag after eighth bit or stop start.
// - Rx flag at eighth bit or mid-stop.
// - Shift mode: data on rx pin, clock tx.
// - Shift mode starts by write or enable.
// - 8-bit frame: start, eight LSB first, stop.
// - Timer overflow pulses set the bit rate.
// - Data write puts stop bit in position nine.
// - Rx starts on falling edge, checks start.
// - Completed frame loads data, ninth, flag.
// - Frame discarded unless flag clear, stop good.
// - 9-bit frames carry eleven bits total.
// - Fixed mode runs at core/32 or core/16.
module suart_top
   import suart_pkg::*;
(
   input  wire logic       clk_sys_in,         // Core clock, 100 MHz.
   input  wire logic       rst_b_in,           // Asynchronous reset, active low.
   input  wire logic [7:0] sfr_addr_in,        // Register address.
   input  wire logic       sfr_wr_in,          // Register write strobe.
   input  wire logic       sfr_rd_in,          // Register read strobe.
   input  wire logic [7:0] sfr_wdata_in,       // Register write data.
   output logic      [7:0] sfr_rdata_out,      // Register read data, one cycle later.
   input  wire logic       tx_tick_in,         // Transmit timer overflow pulse.
   input  wire logic       rx_tick_in,         // Receive timer overflow pulse.
   input  wire logic       rate_double_bit_in, // Rate doubling for the fixed-rate mode.
   input  wire logic       rxd_in,             // Level seen on the receive pin.
   output logic            rxd_out,            // Shift-mode data driven on the receive pin.
   output logic            rxd_oe_out,         // High while the receive pin is driven.
   output logic            txd_out,            // Transmit pin: frame data or shift clock.
   output logic            tx_buf_ready_out    // High while the transmit buffer has room.
);

   // ********************************************************************
   // Declarations
   // ********************************************************************
   suart_ctrl_t ctrl_reg;          // Control and status register.
   logic [7:0]  rx_data_reg;       // Receive data register, read side of the data address.
   logic [7:0]  buf_mem [0:1];     // Two-entry transmit buffer storage.
   logic        buf_wr_ptr_reg;    // Buffer write pointer.
   logic        buf_rd_ptr_reg;    // Buffer read pointer.
   logic [1:0]  buf_cnt_reg;       // Entries held in the buffer.
   logic [1:0]  buf_cnt_next;      // Entry count after this cycle.
   logic        buf_in_valid;      // Software offers a byte.
   logic        buf_in_ready;      // Buffer can take a byte.
   logic        buf_out_valid;     // Buffer holds a byte for the transmitter.
   logic        buf_out_ready;     // Transmitter can take a byte.
   logic        buf_push;          // Byte enters the buffer.
   logic        buf_pop;           // Byte leaves the buffer.
   logic        shift_mode;        // Shift-register mode is selected.
   logic        fix_pre_reg;       // Prescaler for the fixed-rate mode.
   logic        fix_tick;          // Sixteenth-bit tick in the fixed-rate mode.
   logic        tx_tick16;         // Sixteenth-bit tick for the transmitter.
   logic        rx_tick16;         // Sixteenth-bit tick for the receiver.
   logic        sh_phase_reg;      // Shift clock phase, low then high.
   logic        tx_busy_reg;       // Transmitter is sending.
   logic [10:0] tx_shift_reg;      // Transmit shift register, bit 0 goes out first.
   logic [3:0]  tx_bit_reg;        // Bits sent in the current frame.
   logic [3:0]  tx_tick_reg;       // Ticks within the current transmit bit.
   logic        tx_flag_set;       // Pulse that sets the transmit flag.
   logic        rx_busy_reg;       // Receiver is assembling a frame.
   logic [7:0]  rx_shift_reg;      // Receive shift register.
   logic [3:0]  rx_bit_reg;        // Bits sampled in the current frame, start bit included.
   logic [3:0]  rx_tick_reg;       // Ticks within the current receive bit.
   logic        rx_ninth_reg;      // Captured ninth bit in the 9-bit modes.
   logic        rxd_prev_reg;      // Receive pin one cycle ago, for edge detection.
   logic        rx_done_set;       // Pulse that loads a frame and sets the receive flag.
   logic [7:0]  rx_load_data;      // Byte loaded with that pulse.
   logic        rx_load_ninth;     // Ninth-bit field loaded with that pulse.
   logic        rx_stop_ok;        // Stop bit sampled as one.
   logic        rx_mp_ok;          // Multiprocessor filter passes.

   assign shift_mode = (ctrl_reg.mode == SUART_MODE_SHIFT);

   // ********************************************************************
   // Rate ticks
   // ********************************************************************

   // Fixed-rate prescaler: a tick every other clock gives 32 clocks a bit,
   // a tick every clock gives 16 clocks a bit when doubling is on.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fix_pre_reg <= 1'b0;
      end else begin
         fix_pre_reg <= ~fix_pre_reg;
      end
   end

   assign fix_tick = rate_double_bit_in | fix_pre_reg;

   // Modes 01 and 11 use the timer pulses, mode 10 the fixed prescaler.
   // The transmit and receive pulses are separate ports so that one timer
   // can feed both, or two timers each feed one direction.
   assign tx_tick16 = (ctrl_reg.mode == SUART_MODE_ASY9F) ? fix_tick : tx_tick_in;
   assign rx_tick16 = (ctrl_reg.mode == SUART_MODE_ASY9F) ? fix_tick : rx_tick_in;

   // Shift clock phase toggles every core clock, one bit per two clocks.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sh_phase_reg <= 1'b0;
      end else begin
         sh_phase_reg <= ~sh_phase_reg;
      end
   end

   // ********************************************************************
   // Transmit buffer
   // ********************************************************************

   // A write to the data address offers a byte; a full buffer drops it, and
   // tx_buf_ready_out warns software beforehand.
   assign buf_in_valid  = sfr_wr_in && (sfr_addr_in == SUART_DATA_ADDR);
   assign buf_in_ready  = (buf_cnt_reg != SUART_BUF_DEPTH);
   assign buf_push      = buf_in_valid && buf_in_ready;
   assign buf_out_valid = (buf_cnt_reg != 2'h0);
   // In shift mode the pins are shared, so a reception in progress stalls the buffer.
   assign buf_out_ready = !tx_busy_reg && !(shift_mode && rx_busy_reg);
   assign buf_pop       = buf_out_valid && buf_out_ready;

   // Entry count for the next cycle.
   always_comb begin
      buf_cnt_next = buf_cnt_reg;
      if (buf_push && !buf_pop) begin
         buf_cnt_next = buf_cnt_reg + 2'h1;
      end else if (buf_pop && !buf_push) begin
         buf_cnt_next = buf_cnt_reg - 2'h1;
      end
   end

   // Buffer pointers, count and registered ready.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         buf_wr_ptr_reg   <= 1'b0;
         buf_rd_ptr_reg   <= 1'b0;
         buf_cnt_reg      <= 2'h0;
         tx_buf_ready_out <= 1'b1;
      end else begin
         buf_cnt_reg      <= buf_cnt_next;
         tx_buf_ready_out <= (buf_cnt_next != SUART_BUF_DEPTH);
         if (buf_push) begin
            buf_wr_ptr_reg <= ~buf_wr_ptr_reg;
         end
         if (buf_pop) begin
            buf_rd_ptr_reg <= ~buf_rd_ptr_reg;
         end
      end
   end

   // Buffer storage needs no reset; the count guards every read.
   always_ff @(posedge clk_sys_in) begin
      if (buf_push) begin
         buf_mem[buf_wr_ptr_reg] <= sfr_wdata_in;
      end
   end

   // ********************************************************************
   // Transmitter
   // ********************************************************************

   // One engine serves all modes. Asynchronous frames are start, data LSB
   // first, ninth bit or stop, stop; shift mode sends only the eight data bits.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_busy_reg  <= 1'b0;
         tx_shift_reg <= 11'h7FF;
         tx_bit_reg   <= 4'h0;
         tx_tick_reg  <= 4'h0;
      end else if (buf_pop) begin
         tx_busy_reg <= 1'b1;
         tx_bit_reg  <= 4'h0;
         tx_tick_reg <= 4'h0;
         if (shift_mode) begin
            tx_shift_reg <= {3'h7, buf_mem[buf_rd_ptr_reg]};
         end else if (suart_is_nine(ctrl_reg.mode)) begin
            tx_shift_reg <= {1'b1, ctrl_reg.tx_ninth, buf_mem[buf_rd_ptr_reg], 1'b0};
         end else begin
            tx_shift_reg <= {2'h3, buf_mem[buf_rd_ptr_reg], 1'b0};
         end
      end else if (tx_busy_reg && shift_mode) begin
         // Shift clock high phase ends a bit; the next bit is set up at once.
         if (sh_phase_reg) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_bit_reg   <= tx_bit_reg + 4'h1;
            if (tx_bit_reg[2:0] == SUART_LAST_SHIFT) begin
               tx_busy_reg <= 1'b0;
            end
         end
      end else if (tx_busy_reg && tx_tick16) begin
         tx_tick_reg <= tx_tick_reg + 4'h1;
         if (tx_tick_reg == SUART_LAST_TICK) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_bit_reg   <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == suart_frame_bits(ctrl_reg.mode) - 4'h1) begin
               tx_busy_reg <= 1'b0;
            end
         end
      end
   end

   // Transmit flag: end of the eighth bit in shift mode, entry to the stop
   // bit otherwise.
   assign tx_flag_set = tx_busy_reg &&
      (shift_mode ? (sh_phase_reg && tx_bit_reg[2:0] == SUART_LAST_SHIFT)
                  : (tx_tick16 && tx_tick_reg == SUART_LAST_TICK &&
                     tx_bit_reg == suart_frame_bits(ctrl_reg.mode) - 4'h2));

   // ********************************************************************
   // Receiver
   // ********************************************************************

   // The receiver owns its own shift register, so in the asynchronous modes it can
   // assemble a byte while the previous one waits in rx_data_reg, and runs apart from
   // the transmitter outside shift mode, where the two share the pins.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_busy_reg  <= 1'b0;
         rx_shift_reg <= 8'h00;
         rx_bit_reg   <= 4'h0;
         rx_tick_reg  <= 4'h0;
         rx_ninth_reg <= 1'b0;
         rxd_prev_reg <= 1'b1;
      end else begin
         rxd_prev_reg <= rxd_in;
         if (!ctrl_reg.rx_en) begin
            rx_busy_reg <= 1'b0;
         end else if (shift_mode) begin
            if (!rx_busy_reg) begin
               // Shift mode reception waits for a clear flag and an idle line.
               if (!ctrl_reg.rx_done && !tx_busy_reg && !buf_out_valid && sh_phase_reg) begin
                  rx_busy_reg <= 1'b1;
                  rx_bit_reg  <= 4'h0;
               end
            end else if (sh_phase_reg) begin
               // Data is taken at the end of the clock's high phase.
               rx_shift_reg <= {rxd_in, rx_shift_reg[7:1]};
               rx_bit_reg   <= rx_bit_reg + 4'h1;
               if (rx_bit_reg[2:0] == SUART_LAST_SHIFT) begin
                  rx_busy_reg <= 1'b0;
               end
            end
         end else if (!rx_busy_reg) begin
            // A falling edge on the pin opens a frame.
            if (rxd_prev_reg && !rxd_in) begin
               rx_busy_reg <= 1'b1;
               rx_bit_reg  <= 4'h0;
               rx_tick_reg <= 4'h0;
            end
         end else if (rx_tick16) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == SUART_SAMPLE_TICK) begin
               rx_bit_reg <= rx_bit_reg + 4'h1;
               if (rx_bit_reg == 4'h0) begin
                  // A start bit that reads high at mid-bit was noise.
                  if (rxd_in) begin
                     rx_busy_reg <= 1'b0;
                  end
               end else if (rx_bit_reg <= SUART_RX_DATA_END) begin
                  rx_shift_reg <= {rxd_in, rx_shift_reg[7:1]};
               end else if (rx_bit_reg == SUART_RX_DATA_END + 4'h1 &&
                            suart_is_nine(ctrl_reg.mode)) begin
                  rx_ninth_reg <= rxd_in;
               end else begin
                  // Mid stop bit: the frame is finished here.
                  rx_busy_reg <= 1'b0;
               end
            end
         end
      end
   end

   // Stop bit and filter checks at the mid stop-bit sample.
   assign rx_stop_ok = rxd_in;
   assign rx_mp_ok   = !ctrl_reg.mp_en ||
                       (suart_is_nine(ctrl_reg.mode) ? rx_ninth_reg : rxd_in);

   // Frame completion: eighth shift in shift mode, mid stop bit otherwise.
   // A set receive flag means the frame is discarded.
   always_comb begin
      rx_done_set   = 1'b0;
      rx_load_data  = rx_shift_reg;
      rx_load_ninth = ctrl_reg.rx_ninth;
      if (ctrl_reg.rx_en && rx_busy_reg && shift_mode) begin
         if (sh_phase_reg && rx_bit_reg[2:0] == SUART_LAST_SHIFT) begin
            rx_done_set  = !ctrl_reg.rx_done;
            rx_load_data = {rxd_in, rx_shift_reg[7:1]};
         end
      end else if (ctrl_reg.rx_en && rx_busy_reg && rx_tick16 &&
                   rx_tick_reg == SUART_SAMPLE_TICK &&
                   rx_bit_reg == suart_frame_bits(ctrl_reg.mode) - 4'h1) begin
         rx_done_set   = !ctrl_reg.rx_done && rx_stop_ok && rx_mp_ok;
         // Ninth data bit in 9-bit modes, stop bit in the 8-bit mode.
         rx_load_ninth = suart_is_nine(ctrl_reg.mode) ? rx_ninth_reg : rxd_in;
      end
   end

   // ********************************************************************
   // Registers
   // ********************************************************************

   // Control register: software writes every field; hardware sets the two
   // flags, and a set in the same cycle as a clearing write wins.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_reg <= suart_ctrl_t'(SUART_CTRL_RESET);
      end else begin
         if (sfr_wr_in && sfr_addr_in == SUART_CTRL_ADDR) begin
            ctrl_reg <= suart_ctrl_t'(sfr_wdata_in);
         end
         if (rx_done_set) begin
            ctrl_reg.rx_ninth <= rx_load_ninth;
         end
         if (tx_flag_set) begin
            ctrl_reg.tx_done <= 1'b1;
         end
         if (rx_done_set) begin
            ctrl_reg.rx_done <= 1'b1;
         end
      end
   end

   // Receive data register, separate from the transmit path.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_data_reg <= SUART_DATA_RESET;
      end else if (rx_done_set) begin
         rx_data_reg <= rx_load_data;
      end
   end

   // Read data is registered; unmapped addresses read as zero.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_rd_in) begin
         case (sfr_addr_in)
            SUART_CTRL_ADDR: sfr_rdata_out <= ctrl_reg;
            SUART_DATA_ADDR: sfr_rdata_out <= rx_data_reg;
            default:         sfr_rdata_out <= 8'h00;
         endcase
      end
   end

   // ********************************************************************
   // Pins
   // ********************************************************************

   // Shift mode: data on the receive pin, clock on the transmit pin, low in
   // the first half of each bit. Asynchronous modes drive frame data.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         txd_out    <= 1'b1;
         rxd_out    <= 1'b1;
         rxd_oe_out <= 1'b0;
      end else begin
         rxd_out    <= buf_pop ? buf_mem[buf_rd_ptr_reg][0] : tx_shift_reg[0];
         rxd_oe_out <= shift_mode && (buf_pop || (tx_busy_reg &&
                       !(sh_phase_reg && tx_bit_reg[2:0] == SUART_LAST_SHIFT)));
         if (shift_mode) begin
            txd_out <= !((tx_busy_reg && !(sh_phase_reg &&
                          tx_bit_reg[2:0] == SUART_LAST_SHIFT)) || buf_pop ||
                         (rx_busy_reg && !(sh_phase_reg &&
                          rx_bit_reg[2:0] == SUART_LAST_SHIFT))) || sh_phase_reg;
         end else begin
            txd_out <= (buf_pop || tx_busy_reg) ?
                       (buf_pop ? 1'b0 : tx_shift_reg[0]) : 1'b1;
         end
      end
   end

endmodule

// >>> tb/suart_props.sv
// Checker of the serial port pins, bound to its top module.
`timescale 1ns/1ps
module suart_props
   import suart_pkg::*;
(
   input wire logic       clk_sys_in, rst_b_in, sfr_wr_in, sfr_rd_in, tx_tick_in,
   input wire logic       rxd_oe_out, txd_out, tx_buf_ready_out,
   input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out
);
   logic [1:0] mode_reg;                                    // Mode last written.
   wire        dwr = sfr_wr_in && sfr_addr_in == SUART_DATA_ADDR; // Data write.
   // Mode is tracked from the bus, since the pins alone cannot show it.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) mode_reg <= 2'h0;
      else if (sfr_wr_in && sfr_addr_in == SUART_CTRL_ADDR) mode_reg <= sfr_wdata_in[7:6];
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   // One shift-mode bit: a low phase, then a high phase.
   sequence shift_bit_s;
      !txd_out ##1 txd_out;
   endsequence
   idle_release_a: assert property ($rose(rst_b_in) |-> txd_out && !rxd_oe_out)
      else $error("Pins not idle after reset.");
   unmapped_read_a: assert property (sfr_rd_in && sfr_addr_in != SUART_CTRL_ADDR &&
      sfr_addr_in != SUART_DATA_ADDR |=> sfr_rdata_out == 8'h00) else $error("Bad read.");
   read_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
      else $error("Read data moved.");
   mode_readback_a: assert property (sfr_rd_in && sfr_addr_in == SUART_CTRL_ADDR |=>
      sfr_rdata_out[7:6] == $past(mode_reg)) else $error("Mode read back wrong.");
   pin_drive_a: assert property (rxd_oe_out |-> mode_reg == 2'h0 || $past(mode_reg) == 2'h0)
      else $error("Receive pin driven outside shift mode.");
   buf_full_a: assert property ($fell(tx_buf_ready_out) |-> $past(dwr) || $past(dwr, 2))
      else $error("Buffer filled without a write.");
   shift_clock_a: assert property (mode_reg == 2'h0 && $fell(txd_out) |-> shift_bit_s)
      else $error("Shift clock phase wrong.");
   shift_start_a: assert property ($rose(rxd_oe_out) |-> ##[0:3] !txd_out)
      else $error("No shift clock after drive.");
   tick_paced_a: assert property (mode_reg[0] && $changed(txd_out) |-> $past(tx_tick_in) ||
      $past(tx_tick_in, 2) || $past(tx_tick_in, 3) || $past(tx_tick_in, 4) || $past(dwr, 2) ||
      $past(dwr, 3) || $past(dwr, 4)) else $error("Transmit pin moved off a tick.");
endmodule

bind suart_top suart_props u_props (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
   .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .tx_tick_in(tx_tick_in),
   .rxd_oe_out(rxd_oe_out), .txd_out(txd_out), .tx_buf_ready_out(tx_buf_ready_out),
   .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out));

// >>> tb/suart_peer.sv
// Remote serial peer: sends frames to the receive pin and captures transmitted frames.
`timescale 1ns/1ps
module suart_peer (
   input  wire logic clk_in,
   input  wire logic txd_in,
   output logic      rxd_out
);
   initial rxd_out = 1'b1; // The line idles high, as its pull-up would hold it.
   // Sends n bits, first bit first, each held for per clocks.
   task automatic send(input logic [10:0] fr, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         rxd_out <= fr[i];
         repeat (per - 1) @(posedge clk_in);
      end
   endtask
   // Waits for a start bit, then samples each bit in its middle.
   task automatic get(output logic [10:0] fr, input int n, input int per);
      fr = 11'h000;
      wait (!txd_in);
      repeat (per / 2) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         fr[i] = txd_in;
         repeat (per) @(posedge clk_in);
      end
   endtask
endmodule

// >>> tb/suart_top_tb.sv
// Self-checking bench of the serial port against a serial peer.
`timescale 1ns/1ps
module suart_top_tb
   import suart_pkg::*;
;
   // One case: mode, then filter, ninth bit, rate doubling, flag expected, then data.
   typedef struct packed {logic [1:0] m; logic mp, nin, dbl, flag; logic [7:0] d;} suart_row_t;
   suart_row_t rows [6] = '{{2'h1, 4'h1, 8'hA5}, {2'h1, 4'h9, 8'h5A}, {2'h3, 4'h8, 8'h3C},
                           {2'h3, 4'hD, 8'h96}, {2'h2, 4'h3, 8'h0F}, {2'h2, 4'hD, 8'hC3}};
   logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0;
   logic        dbl = 1'b0, txd, rxd_drv, rxd_oe, ready, peer_rxd;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v;
   logic [2:0]  tcnt = 3'h0;
   logic [10:0] f, got;
   suart_row_t  r;
   int          n, per, failures = 0, tests_run = 0;
   wire         rxd_pin = rxd_oe ? rxd_drv : peer_rxd; // Whoever drives owns the pin.
   suart_top DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sfr_addr_in(addr),
      .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
      .tx_tick_in(tick), .rx_tick_in(tick), .rate_double_bit_in(dbl), .rxd_in(rxd_pin),
      .rxd_out(rxd_drv), .rxd_oe_out(rxd_oe), .txd_out(txd), .tx_buf_ready_out(ready));
   suart_peer peer (.clk_in(clk_sys_in), .txd_in(txd), .rxd_out(peer_rxd));
   initial forever #5 clk_sys_in = ~clk_sys_in;
   // Timer overflow every eight clocks, so one timer-paced bit is 128 clocks.
   always @(posedge clk_sys_in) begin
      tcnt <= tcnt + 3'h1;
      tick <= (tcnt == 3'h7);
   end
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk_sys_in);
      rd <= 1'b0;
      @(posedge clk_sys_in);
      d = rdata; // Registered answer, standing until the next read.
   endtask
   task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // A hang counts as a mismatch; the tests need some 8000 clocks.
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      failures++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         per = r.m[0] ? 128 : (r.dbl ? 16 : 32);
         n = (r.m == SUART_MODE_ASY8) ? 10 : 11;
         f = (n == 10) ? {2'b01, r.d, 1'b0} : {1'b1, r.nin, r.d, 1'b0};
         dbl <= r.dbl;
         wreg(SUART_CTRL_ADDR, {r.m, r.mp, 1'b1, r.nin, 3'h0});
         wreg(SUART_DATA_ADDR, r.d);
         fork // Both directions at once.
            peer.get(got, n, per);
            peer.send(f, n, per);
         join
         chk("frame", f, got);
         rreg(SUART_CTRL_ADDR, v);
         chk("control", 11'({r.m, r.mp, 1'b1, r.nin, r.flag & f[9], 1'b1, r.flag}), 11'(v));
         rreg(SUART_DATA_ADDR, v);
         if (r.flag) chk("rx data", 11'(r.d), 11'(v));
         $display("case %0d done", i);
      end
      peer.send({2'b11, 8'h5A, 1'b0}, 11, 32); // Flag still set: new frame must be lost.
      rreg(SUART_DATA_ADDR, v);
      chk("kept data", 11'h0C3, 11'(v));
      wreg(SUART_CTRL_ADDR, 8'h00);
      wreg(SUART_DATA_ADDR, 8'hB4);
      repeat (8) @(posedge txd) v = {rxd_drv, v[7:1]};
      chk("shift data", 11'h0B4, 11'(v));
      repeat (4) @(posedge clk_sys_in);
      rreg(SUART_CTRL_ADDR, v);
      chk("shift flag", 11'h002, 11'(v));
      $display("shift case done");
      wreg(SUART_CTRL_ADDR, 8'h40);
      repeat (3) wreg(SUART_DATA_ADDR, 8'h81);
      @(posedge clk_sys_in);
      chk("buffer full", 11'h000, 11'(ready));
      wait (ready);
      rreg(8'h97, v);
      chk("unmapped", 11'h000, 11'(v));
      $display("buffer case done");
      rst_b_in <= 1'b0; // Mid-run reset with a byte still queued.
      repeat (2) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      rreg(SUART_CTRL_ADDR, v);
      chk("reset ctrl", 11'h000, 11'(v));
      wreg(SUART_CTRL_ADDR, 8'h10); // Shift receive of an idle line.
      repeat (24) @(posedge clk_sys_in);
      rreg(SUART_DATA_ADDR, v);
      chk("shift rx", 11'h0FF, 11'(v));
      rreg(SUART_CTRL_ADDR, v);
      chk("shift rx flag", 11'h011, 11'(v));
      $display("reset case done");
      conclude();
   end
endmodule
